/* File: cxs_core_defs.vh */
// Constants for the execution core: opcodes, flag positions, reset values.
// Assumes one core clock and synchronous active-high reset.
`ifndef CXS_CORE_DEFS_VH
`define CXS_CORE_DEFS_VH

// Reset values and the interrupt hold-off loaded by a stack pointer low write
`define CXS_RESET_VECTOR 16'h0000
`define CXS_SP_TOP       16'h0fff
`define CXS_HOLDOFF      3'h4

// Flag bit positions
`define CXS_FLAG_C 0
`define CXS_FLAG_Z 1
`define CXS_FLAG_N 2
`define CXS_FLAG_V 3
`define CXS_FLAG_S 4
`define CXS_FLAG_H 5
`define CXS_FLAG_I 7

// I/O addresses inside the core and base of outside I/O
`define CXS_IO_SPL  6'h3d
`define CXS_IO_SPH  6'h3e
`define CXS_IO_RESULT_FLAGS_REGISTER 6'h3f
`define CXS_IO_HI   10'h000

// Register indices
`define CXS_PAIR_BASE 5'h18
`define CXS_PTR_BASE  5'h1a
`define CXS_MUL_DST   5'h00

// Major opcodes, instruction bits 15:12
`define CXS_OP_ARITH 4'h0
`define CXS_OP_LOGIC 4'h1
`define CXS_OP_MUL   4'h2
`define CXS_OP_WORD  4'h3
`define CXS_OP_SUBI  4'h4
`define CXS_OP_ANDI  4'h5
`define CXS_OP_ORI   4'h6
`define CXS_OP_LDI   4'h7
`define CXS_OP_CPI   4'h8
`define CXS_OP_UNARY 4'h9
`define CXS_OP_LDST  4'ha
`define CXS_OP_STACK 4'hb
`define CXS_OP_IO    4'hc
`define CXS_OP_RJMP  4'hd
`define CXS_OP_RELATIVE_SUBROUTINE_INVOKE 4'he
`define CXS_OP_MISC  4'hf

// Unary sub-operations, bits 10:8
`define CXS_UN_INC  3'h0
`define CXS_UN_DEC  3'h1
`define CXS_UN_COM  3'h2
`define CXS_UN_NEG  3'h3
`define CXS_UN_LSR  3'h4
`define CXS_UN_ROR  3'h5
`define CXS_UN_BSET 3'h6
`define CXS_UN_BCLR 3'h7

// Addressing modes, bits 10:8
`define CXS_AM_IND  3'h0
`define CXS_AM_INC  3'h1
`define CXS_AM_DEC  3'h2
`define CXS_AM_DISP 3'h3
`define CXS_AM_DIR  3'h4

// Flow sub-operations, bits 10:8 with bit 11 low
`define CXS_FL_JMP   3'h0
`define CXS_FL_CALL  3'h1
`define CXS_FL_IJMP  3'h2
`define CXS_FL_INDIRECT_SUBROUTINE_INVOKE 3'h3
`define CXS_FL_RET   3'h4
`define CXS_FL_INTERRUPT_EXIT  3'h5

`endif

/* File: cxs_core.v */
// Execution core: fetch, ALU, multiplier, register file and stack pointer.
// Assumes program and data memories answer combinationally to the
// registered addresses; interrupt request is a level from a controller.
`timescale 1ns/1ps
`include "cxs_core_defs.vh"

module cxs_core (
	input  wire        clock,
	input  wire        reset,
	output wire [15:0] prog_addr,
	input  wire [15:0] prog_data,
	output wire [15:0] dm_addr,
	output wire [7:0]  dm_wdata,
	output wire        dm_we,
	output wire        dm_re,
	input  wire [7:0]  dm_rdata,
	input  wire        irq_req,
	input  wire [15:0] irq_vector,
	output wire        irq_ack,
	output wire [7:0]  result_flags_register,
	output wire [15:0] stack_pointer
);

	localparam [5:0] ST_EXEC  = 6'h01;
	localparam [5:0] ST_MUL   = 6'h02;
	localparam [5:0] ST_LOAD  = 6'h04;
	localparam [5:0] ST_PUSH2 = 6'h08;
	localparam [5:0] ST_RET1  = 6'h10;
	localparam [5:0] ST_RET2  = 6'h20;

	reg  [7:0]  rf_ff [0:31];
	reg  [5:0]  state_ff, nxt_state;
	reg  [15:0] pc_ff, nxt_pc;
	reg  [15:0] ir_ff, nxt_ir;
	reg         irok_ff, nxt_irok;
	reg  [7:0]  flags_ff, nxt_flags;
	reg  [7:0]  sp_lo_ff, nxt_sp_lo;
	reg  [7:0]  sp_hi_ff, nxt_sp_hi;
	reg  [2:0]  hold_ff, nxt_hold;
	reg  [15:0] ret_ff, nxt_ret;
	reg  [15:0] tgt_ff, nxt_tgt;
	reg  [15:0] dm_addr_ff, nxt_dm_addr;
	reg  [7:0]  dm_wdata_ff, nxt_dm_wdata;
	reg         dm_we_ff, nxt_dm_we;
	reg         dm_re_ff, nxt_dm_re;
	reg         ack_ff, nxt_ack;
	reg         rf_we8, rf_we16, advance, do_push;
	reg  [4:0]  rf_wa8, rf_wa16;
	reg  [7:0]  rf_wd8;
	reg  [15:0] rf_wd16, ea;
	reg  [7:0]  ax, by, lr, alu_r, alu_f;
	reg         asub, acin, use_add, lc;
	reg  [8:0]  sum9;
	reg  [16:0] w17;
	reg  [7:0]  w_f, m_f;
	reg  [8:0]  ma, mb;
	reg  [17:0] mprod;
	reg  [15:0] mres;

	// Instruction fields
	wire [3:0]  op   = ir_ff[15:12];
	wire [4:0]  rd   = ir_ff[4:0];
	wire [4:0]  rda  = ir_ff[9:5];
	wire [4:0]  rdh  = {1'b1, ir_ff[7:4]};
	wire [7:0]  imm8 = {ir_ff[11:8], ir_ff[3:0]};
	wire [2:0]  sub3 = ir_ff[10:8];
	wire        immop = (op >= `CXS_OP_SUBI) && (op <= `CXS_OP_CPI);
	wire [7:0]  opa = immop ? rf_ff[rdh] : rf_ff[rda];
	wire [7:0]  opb = immop ? imm8 : rf_ff[ir_ff[4:0]];
	wire [7:0]  una = rf_ff[rd];
	wire [4:0]  pidx = `CXS_PAIR_BASE + {2'b00, ir_ff[10:9], 1'b0};
	wire [15:0] pval = {rf_ff[pidx + 5'h01], rf_ff[pidx]};
	wire [4:0]  xidx = `CXS_PTR_BASE + {2'b00, ir_ff[7:6], 1'b0};
	wire [15:0] ptr  = {rf_ff[xidx + 5'h01], rf_ff[xidx]};
	wire [15:0] zptr = {rf_ff[5'h1f], rf_ff[5'h1e]};
	wire [15:0] sp   = {sp_hi_ff, sp_lo_ff};
	wire [15:0] sp_top = `CXS_SP_TOP;                          // Split per byte
	wire        two_word = (sub3 == `CXS_AM_DISP) || (sub3 == `CXS_AM_DIR);
	wire        irq_take = irq_req && flags_ff[`CXS_FLAG_I] &&
	                       (hold_ff == 3'h0);

	// 8-bit ALU: adder path and logic path with flag results
	always @*
	begin
		ax = opa;
		by = opb;
		asub = 1'b0;
		acin = 1'b0;
		use_add = 1'b1;
		lr = opa;
		lc = flags_ff[`CXS_FLAG_C];
		case (op)
		`CXS_OP_ARITH:
		begin
			asub = ir_ff[11];
			acin = ir_ff[10] & flags_ff[`CXS_FLAG_C];
		end
		`CXS_OP_SUBI, `CXS_OP_CPI: asub = 1'b1;
		`CXS_OP_UNARY:
		begin
			ax = una;
			by = 8'h01;
			case (sub3)
			`CXS_UN_INC: asub = 1'b0;
			`CXS_UN_DEC: asub = 1'b1;
			`CXS_UN_NEG:
			begin
				ax = 8'h00;
				by = una;
				asub = 1'b1;
			end
			default: use_add = 1'b0;
			endcase
		end
		default: use_add = 1'b0;
		endcase
		sum9 = asub ? ({1'b0, ax} - {1'b0, by} - {8'h00, acin})
		            : ({1'b0, ax} + {1'b0, by} + {8'h00, acin});
		case (op)
		`CXS_OP_LOGIC:
			case (ir_ff[11:10])
			2'h0: lr = opa & opb;
			2'h1: lr = opa | opb;
			2'h2: lr = opa ^ opb;
			default: lr = opb;
			endcase
		`CXS_OP_ANDI: lr = opa & opb;
		`CXS_OP_ORI: lr = opa | opb;
		`CXS_OP_LDI: lr = opb;
		`CXS_OP_UNARY:
			case (sub3)
			`CXS_UN_COM:
			begin
				lr = ~una;
				lc = 1'b1;
			end
			`CXS_UN_LSR:
			begin
				lr = {1'b0, una[7:1]};
				lc = una[0];
			end
			`CXS_UN_ROR:
			begin
				lr = {flags_ff[`CXS_FLAG_C], una[7:1]};
				lc = una[0];
			end
			default: lr = una;
			endcase
		default: lr = opa;
		endcase
		alu_r = use_add ? sum9[7:0] : lr;
		// Flags reflect the result just produced
		alu_f = flags_ff;
		alu_f[`CXS_FLAG_N] = alu_r[7];
		alu_f[`CXS_FLAG_Z] = (alu_r == 8'h00);
		if (use_add)
		begin
			alu_f[`CXS_FLAG_H] = asub ?
				(~ax[3] & by[3]) | (by[3] & alu_r[3]) | (alu_r[3] & ~ax[3]) :
				(ax[3] & by[3]) | (by[3] & ~alu_r[3]) | (~alu_r[3] & ax[3]);
			alu_f[`CXS_FLAG_V] = asub ?
				(ax[7] & ~by[7] & ~alu_r[7]) | (~ax[7] & by[7] & alu_r[7]) :
				(ax[7] & by[7] & ~alu_r[7]) | (~ax[7] & ~by[7] & alu_r[7]);
			if (op != `CXS_OP_UNARY || sub3 == `CXS_UN_NEG)
				alu_f[`CXS_FLAG_C] = sum9[8];
		end
		else
		begin
			alu_f[`CXS_FLAG_C] = lc;
			alu_f[`CXS_FLAG_V] = (op == `CXS_OP_UNARY &&
				(sub3 == `CXS_UN_LSR || sub3 == `CXS_UN_ROR)) ?
				(alu_r[7] ^ lc) : 1'b0;
		end
		alu_f[`CXS_FLAG_S] = alu_f[`CXS_FLAG_N] ^ alu_f[`CXS_FLAG_V];
	end

	// 16-bit pair add/subtract of a six-bit constant and the multiplier
	always @*
	begin
		w17 = ir_ff[11] ? ({1'b0, pval} - {11'h000, ir_ff[5:0]})
		                : ({1'b0, pval} + {11'h000, ir_ff[5:0]});
		w_f = flags_ff;
		w_f[`CXS_FLAG_C] = w17[16];
		w_f[`CXS_FLAG_Z] = (w17[15:0] == 16'h0000);
		w_f[`CXS_FLAG_N] = w17[15];
		w_f[`CXS_FLAG_V] = ir_ff[11] ? (pval[15] & ~w17[15])
		                             : (~pval[15] & w17[15]);
		w_f[`CXS_FLAG_S] = w_f[`CXS_FLAG_N] ^ w_f[`CXS_FLAG_V];
		// Bits 11:10 pick unsigned, signed or signed-by-unsigned
		ma = {ir_ff[11:10] != 2'h0 && rf_ff[rdh][7], rf_ff[rdh]};
		mb = {ir_ff[11:10] == 2'h1 && rf_ff[{1'b1, ir_ff[3:0]}][7],
		      rf_ff[{1'b1, ir_ff[3:0]}]};
		mprod = $signed(ma) * $signed(mb);
		mres = ir_ff[8] ? {mprod[14:0], 1'b0} : mprod[15:0];
		m_f = flags_ff;
		m_f[`CXS_FLAG_C] = mprod[15];
		m_f[`CXS_FLAG_Z] = (mres == 16'h0000);
	end

	// Next-state logic for fetch, execute and stack sequencing
	always @*
	begin
		nxt_state = state_ff;
		nxt_pc = pc_ff;
		nxt_ir = ir_ff;
		nxt_irok = irok_ff;
		nxt_flags = flags_ff;
		{nxt_sp_hi, nxt_sp_lo} = sp;
		nxt_hold = hold_ff;
		nxt_ret = ret_ff;
		nxt_tgt = tgt_ff;
		nxt_dm_addr = dm_addr_ff;
		nxt_dm_wdata = dm_wdata_ff;
		nxt_dm_we = 1'b0;
		nxt_dm_re = 1'b0;
		nxt_ack = 1'b0;
		rf_we8 = 1'b0;
		rf_wa8 = rd;
		rf_wd8 = alu_r;
		rf_we16 = 1'b0;
		rf_wa16 = pidx;
		rf_wd16 = w17[15:0];
		advance = 1'b0;
		do_push = 1'b0;
		ea = ptr;
		case (state_ff)
		ST_EXEC:
			if (!irok_ff)
				advance = 1'b1;
			else if (irq_take)
			begin
				nxt_ret = pc_ff - 16'h0001;         // Re-run the held instruction
				nxt_tgt = irq_vector;
				nxt_flags[`CXS_FLAG_I] = 1'b0;      // Other flags untouched
				nxt_ack = 1'b1;
				do_push = 1'b1;
			end
			else
			begin
				advance = 1'b1;
				if (hold_ff != 3'h0)
					nxt_hold = hold_ff - 3'h1;
				case (op)
				`CXS_OP_ARITH, `CXS_OP_LOGIC, `CXS_OP_SUBI, `CXS_OP_ANDI,
				`CXS_OP_ORI, `CXS_OP_LDI:
				begin
					rf_we8 = 1'b1;
					rf_wa8 = immop ? rdh : rda;
					if (op != `CXS_OP_LDI &&
					    !(op == `CXS_OP_LOGIC && ir_ff[11:10] == 2'h3))
						nxt_flags = alu_f;
				end
				`CXS_OP_CPI: nxt_flags = alu_f;
				`CXS_OP_UNARY:
					if (sub3 == `CXS_UN_BSET)
						nxt_flags[ir_ff[7:5]] = 1'b1;
					else if (sub3 == `CXS_UN_BCLR)
						nxt_flags[ir_ff[7:5]] = 1'b0;
					else
					begin
						rf_we8 = 1'b1;
						nxt_flags = alu_f;
					end
				`CXS_OP_WORD:
				begin
					rf_we16 = 1'b1;
					nxt_flags = w_f;
				end
				`CXS_OP_MUL:
				begin
					advance = 1'b0;
					nxt_state = ST_MUL;
				end
				`CXS_OP_LDST:
				begin
					case (sub3)
					`CXS_AM_DEC: ea = ptr - 16'h0001;
					`CXS_AM_DISP: ea = ptr + prog_data;
					`CXS_AM_DIR: ea = prog_data;
					default: ea = ptr;
					endcase
					rf_wa16 = xidx;
					rf_we16 = (sub3 == `CXS_AM_INC) || (sub3 == `CXS_AM_DEC);
					rf_wd16 = (sub3 == `CXS_AM_INC) ? ptr + 16'h0001 : ea;
					nxt_dm_addr = ea;
					nxt_dm_wdata = una;
					nxt_dm_we = ir_ff[11];
					nxt_dm_re = !ir_ff[11];
					if (two_word)
					begin
						nxt_pc = pc_ff + 16'h0001;
						advance = 1'b0;
						nxt_irok = ir_ff[11] ? 1'b0 : irok_ff;
					end
					if (!ir_ff[11])
					begin
						advance = 1'b0;
						nxt_state = ST_LOAD;
					end
				end
				`CXS_OP_STACK:
					if (!ir_ff[11])
					begin
						nxt_dm_we = 1'b1;
						nxt_dm_addr = sp;
						nxt_dm_wdata = una;
						{nxt_sp_hi, nxt_sp_lo} = sp - 16'h0001;
					end
					else
					begin
						nxt_dm_re = 1'b1;
						nxt_dm_addr = sp + 16'h0001;
						{nxt_sp_hi, nxt_sp_lo} = sp + 16'h0001;
						advance = 1'b0;
						nxt_state = ST_LOAD;
					end
				`CXS_OP_IO:
					if (ir_ff[11])
					begin
						nxt_hold = 3'h0;
						if (ir_ff[10:5] == `CXS_IO_SPL)
						begin
							nxt_sp_lo = una;
							nxt_hold = `CXS_HOLDOFF;
						end
						else if (ir_ff[10:5] == `CXS_IO_SPH)
							nxt_sp_hi = una;
						else if (ir_ff[10:5] == `CXS_IO_RESULT_FLAGS_REGISTER)
							nxt_flags = una;
						else
						begin
							nxt_dm_we = 1'b1;
							nxt_dm_addr = {`CXS_IO_HI, ir_ff[10:5]};
							nxt_dm_wdata = una;
						end
					end
					else if (ir_ff[10:5] == `CXS_IO_SPL)
					begin
						rf_we8 = 1'b1;
						rf_wd8 = sp_lo_ff;
					end
					else if (ir_ff[10:5] == `CXS_IO_SPH)
					begin
						rf_we8 = 1'b1;
						rf_wd8 = sp_hi_ff;
					end
					else if (ir_ff[10:5] == `CXS_IO_RESULT_FLAGS_REGISTER)
					begin
						rf_we8 = 1'b1;
						rf_wd8 = flags_ff;
					end
					else
					begin
						nxt_dm_re = 1'b1;
						nxt_dm_addr = {`CXS_IO_HI, ir_ff[10:5]};
						advance = 1'b0;
						nxt_state = ST_LOAD;
					end
				`CXS_OP_RJMP:
				begin
					advance = 1'b0;
					nxt_pc = pc_ff + {{4{ir_ff[11]}}, ir_ff[11:0]};
					nxt_irok = 1'b0;
				end
				`CXS_OP_RELATIVE_SUBROUTINE_INVOKE:
				begin
					nxt_ret = pc_ff;
					nxt_tgt = pc_ff + {{4{ir_ff[11]}}, ir_ff[11:0]};
					do_push = 1'b1;
				end
				default:
					if (ir_ff[11])
					begin
						if (flags_ff[ir_ff[10:8]])
						begin
							advance = 1'b0;
							nxt_pc = pc_ff + {{8{ir_ff[7]}}, ir_ff[7:0]};
							nxt_irok = 1'b0;
						end
					end
					else
						case (sub3)
						`CXS_FL_JMP, `CXS_FL_IJMP:
						begin
							advance = 1'b0;
							nxt_pc = (sub3 == `CXS_FL_JMP) ? prog_data : zptr;
							nxt_irok = 1'b0;
						end
						`CXS_FL_CALL, `CXS_FL_INDIRECT_SUBROUTINE_INVOKE:
						begin
							nxt_ret = (sub3 == `CXS_FL_CALL) ?
								pc_ff + 16'h0001 : pc_ff;
							nxt_tgt = (sub3 == `CXS_FL_CALL) ? prog_data : zptr;
							do_push = 1'b1;
						end
						`CXS_FL_RET, `CXS_FL_INTERRUPT_EXIT:
						begin
							advance = 1'b0;
							nxt_dm_re = 1'b1;
							nxt_dm_addr = sp + 16'h0001;
							{nxt_sp_hi, nxt_sp_lo} = sp + 16'h0001;
							nxt_state = ST_RET1;
						end
						default: advance = 1'b1;
						endcase
				endcase
			end
		ST_MUL:
		begin
			rf_we16 = 1'b1;
			rf_wa16 = `CXS_MUL_DST;
			rf_wd16 = mres;
			nxt_flags = m_f;
			advance = 1'b1;
			nxt_state = ST_EXEC;
		end
		ST_LOAD:
		begin
			rf_we8 = 1'b1;
			rf_wd8 = dm_rdata;
			advance = 1'b1;
			nxt_state = ST_EXEC;
		end
		ST_PUSH2:
		begin
			nxt_dm_we = 1'b1;
			nxt_dm_addr = sp;
			nxt_dm_wdata = ret_ff[15:8];
			{nxt_sp_hi, nxt_sp_lo} = sp - 16'h0001;
			nxt_pc = tgt_ff;
			nxt_irok = 1'b0;
			nxt_state = ST_EXEC;
		end
		ST_RET1:
		begin
			nxt_ret = {dm_rdata, ret_ff[7:0]};             // High byte comes first
			nxt_dm_re = 1'b1;
			nxt_dm_addr = sp + 16'h0001;
			{nxt_sp_hi, nxt_sp_lo} = sp + 16'h0001;
			nxt_state = ST_RET2;
		end
		default:
		begin
			nxt_pc = {ret_ff[15:8], dm_rdata};
			nxt_irok = 1'b0;
			if (sub3 == `CXS_FL_INTERRUPT_EXIT)
				nxt_flags[`CXS_FLAG_I] = 1'b1;               // Only I is restored
			nxt_state = ST_EXEC;
		end
		endcase
		// First return byte (low) goes to the higher address
		if (do_push)
		begin
			advance = 1'b0;
			nxt_dm_we = 1'b1;
			nxt_dm_addr = sp;
			nxt_dm_wdata = nxt_ret[7:0];
			{nxt_sp_hi, nxt_sp_lo} = sp - 16'h0001;
			nxt_state = ST_PUSH2;
		end
		// Take the prefetched word and fetch the following one
		if (advance)
		begin
			nxt_ir = prog_data;
			nxt_pc = pc_ff + 16'h0001;
			nxt_irok = 1'b1;
		end
	end

	// Working register file, one write path per entry
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1)
		begin : g_rf
			localparam [4:0] IDX = gi;
			always @(posedge clock)
			begin
				if (reset)
					rf_ff[IDX] <= 8'h00;
				else if (rf_we8 && rf_wa8 == IDX)
					rf_ff[IDX] <= rf_wd8;
				else if (rf_we16 && rf_wa16 == IDX)
					rf_ff[IDX] <= rf_wd16[7:0];
				else if (rf_we16 && rf_wa16 + 5'h01 == IDX)
					rf_ff[IDX] <= rf_wd16[15:8];
			end
		end
	endgenerate

	// All control state on the undivided core clock
	always @(posedge clock)
	begin
		if (reset)
		begin
			state_ff <= ST_EXEC;
			pc_ff <= `CXS_RESET_VECTOR;
			ir_ff <= 16'h0000;
			irok_ff <= 1'b0;
			flags_ff <= 8'h00;
			sp_lo_ff <= sp_top[7:0];
			sp_hi_ff <= sp_top[15:8];
			hold_ff <= 3'h0;
			ret_ff <= 16'h0000;
			tgt_ff <= 16'h0000;
			dm_addr_ff <= 16'h0000;
			dm_wdata_ff <= 8'h00;
			dm_we_ff <= 1'b0;
			dm_re_ff <= 1'b0;
			ack_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			pc_ff <= nxt_pc;
			ir_ff <= nxt_ir;
			irok_ff <= nxt_irok;
			flags_ff <= nxt_flags;
			sp_lo_ff <= nxt_sp_lo;
			sp_hi_ff <= nxt_sp_hi;
			hold_ff <= nxt_hold;
			ret_ff <= nxt_ret;
			tgt_ff <= nxt_tgt;
			dm_addr_ff <= nxt_dm_addr;
			dm_wdata_ff <= nxt_dm_wdata;
			dm_we_ff <= nxt_dm_we;
			dm_re_ff <= nxt_dm_re;
			ack_ff <= nxt_ack;
		end
	end

	// Outputs straight from flip-flops
	assign prog_addr = pc_ff;
	assign dm_addr = dm_addr_ff;
	assign dm_wdata = dm_wdata_ff;
	assign dm_we = dm_we_ff;
	assign dm_re = dm_re_ff;
	assign irq_ack = ack_ff;
	assign result_flags_register = flags_ff;
	assign stack_pointer = sp;

endmodule

/* File: cxs_mem_model.sv */
// Program and data memory model standing on the far side of the core.
// Assumes the core expects combinational answers on both buses.
`timescale 1ns/1ps

module cxs_mem_model (
	input  logic        clock,
	input  logic [15:0] prog_addr,
	output logic [15:0] prog_data,
	input  logic [15:0] dm_addr,
	input  logic [7:0]  dm_wdata,
	input  logic        dm_we,
	input  logic        dm_re,
	output logic [7:0]  dm_rdata
);
	logic [15:0] prog [0:255];
	logic [7:0]  dram [0:4095];

	// Instruction word answers within the same cycle
	assign prog_data = prog[prog_addr[7:0]];
	// Released read bus shows inverted data so stale values never match
	assign dm_rdata = dm_re ? dram[dm_addr[11:0]] : ~dram[dm_addr[11:0]];

	// Byte write at the edge that closes a write cycle
	always @(posedge clock)
		if (dm_we)
			dram[dm_addr[11:0]] <= dm_wdata;
endmodule

/* File: cxs_core_properties.sv */
// Concurrent checks on the execution core ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps

module cxs_core_properties (
	input logic        clock,
	input logic        reset,
	input logic [15:0] prog_addr,
	input logic [15:0] prog_data,
	input logic [15:0] dm_addr,
	input logic [7:0]  dm_wdata,
	input logic        dm_we,
	input logic        dm_re,
	input logic [7:0]  dm_rdata,
	input logic        irq_req,
	input logic [15:0] irq_vector,
	input logic        irq_ack,
	input logic [7:0]  result_flags_register,
	input logic [15:0] stack_pointer
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// Stack pointer low byte written by software, not by a stack access
	sequence s_spl_write;
		$changed(stack_pointer[7:0]) && !dm_we && !dm_re &&
			!$past(dm_we) && !$past(dm_re) && !$past(reset);
	endsequence

	// Fetch starts at word zero and advances on the next edge
	chk_fetch_from_zero: assert property (
		$fell(reset) |-> prog_addr == 16'h0000 ##1 prog_addr == 16'h0001)
		else $error("fetch after reset wrong");
	chk_sp_reset_top: assert property (
		$fell(reset) |-> stack_pointer == 16'h0fff)
		else $error("stack pointer reset value wrong");
	// Each stack byte moves the pointer by one
	chk_push_down: assert property (
		dm_we && dm_addr == $past(stack_pointer)
		|-> stack_pointer == $past(stack_pointer) - 16'h0001)
		else $error("push did not lower stack pointer");
	chk_pop_up: assert property (
		dm_re && dm_addr == $past(stack_pointer) + 16'h0001
		|-> stack_pointer == $past(stack_pointer) + 16'h0001)
		else $error("pop did not raise stack pointer");
	// Interrupt entry writes exactly two bytes, downward
	chk_irq_two_pushes: assert property (
		irq_ack |-> dm_we ##1 (dm_we && dm_addr == $past(dm_addr) - 16'h0001)
		##1 !dm_we)
		else $error("interrupt entry writes wrong");
	chk_irq_sp_minus_two: assert property (
		irq_ack |-> ##2 stack_pointer == $past(dm_addr, 2) - 16'h0002)
		else $error("interrupt entry pointer wrong");
	chk_irq_vector_jump: assert property (
		irq_ack |=> prog_addr == $past(irq_vector, 2))
		else $error("interrupt target fetch wrong");
	chk_spl_holdoff: assert property (
		s_spl_write |-> !irq_ack [*2])
		else $error("interrupt taken right after pointer write");

	cover property (irq_ack);
	cover property (dm_re && dm_addr == $past(stack_pointer) + 16'h0001);
	cover property (dm_we && dm_addr == $past(stack_pointer));
endmodule

bind cxs_core cxs_core_properties chk (
	.clock, .reset, .prog_addr, .prog_data, .dm_addr, .dm_wdata, .dm_we,
	.dm_re, .dm_rdata, .irq_req, .irq_vector, .irq_ack,
	.result_flags_register, .stack_pointer);

/* File: test_cpu_core_exec_and_stack.sv */
// Self-checking bench: small programs run from the memory model.
// Assumes the memory model and the bound checker compile beside it.
`timescale 1ns/1ps

module test_cpu_core_exec_and_stack;
	logic        clock;
	logic        reset;
	logic        irq_req;
	logic        irq_arm;
	logic [15:0] irq_vector;
	logic [7:0]  we_flags;
	wire  [15:0] prog_addr, prog_data, dm_addr, stack_pointer;
	wire  [7:0]  dm_wdata, dm_rdata, result_flags_register;
	wire         dm_we, dm_re, irq_ack;
	int          num_errors, compares, tick, cyc, nwr;
	int          first_we, sp_cyc, ack_cyc;

	cxs_core dut (.clock, .reset, .prog_addr, .prog_data, .dm_addr,
		.dm_wdata, .dm_we, .dm_re, .dm_rdata, .irq_req, .irq_vector,
		.irq_ack, .result_flags_register, .stack_pointer);
	cxs_mem_model mem (.clock, .prog_addr, .prog_data, .dm_addr, .dm_wdata,
		.dm_we, .dm_re, .dm_rdata);

	// 200 MHz core clock
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Records writes, first write cycle, stack move and acknowledge
	always @(posedge clock)
	begin
		if (!reset)
		begin
			if (dm_we && first_we < 0)
			begin
				first_we = cyc;
				we_flags = result_flags_register;
			end
			nwr += dm_we;
			if (stack_pointer[7:0] == 8'hf0 && sp_cyc < 0)
				sp_cyc = cyc;
			if (irq_ack && ack_cyc < 0)
				ack_cyc = cyc;
			cyc++;
		end
		tick++;
		if (tick == 2000)
		begin
			num_errors++;
			summarize;
		end
	end

	// Request rises once the stack moved, falls on acknowledge
	always @(negedge clock)
		irq_req <= irq_arm && sp_cyc >= 0 && ack_cyc < 0 && !irq_ack;

	task automatic check8(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %h got %h", what, exp, got);
		end
	endtask

	task automatic check16(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %h got %h", what, exp, got);
		end
	endtask

	task automatic check_cnt(input string what, input int exp, input int got);
		compares++;
		if (got != exp)
		begin
			num_errors++;
			$display("FAIL %s expected %0d got %0d", what, exp, got);
		end
	endtask

	task automatic summarize;
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Loads a program, resets for four cycles, then runs
	task automatic run_prog(input logic [15:0] p[$], input int ncyc);
		reset = 1'b1;
		for (int i = 0; i < 256; i++)
			mem.prog[i] = (i < p.size()) ? p[i] : 16'hdfff;
		repeat (4) @(negedge clock);
		check16("reset fetch", 16'h0000, prog_addr);
		check16("reset stack", 16'h0fff, stack_pointer);
		cyc = 0;
		nwr = 0;
		first_we = -1;
		sp_cyc = -1;
		ack_cyc = -1;
		reset = 1'b0;
		repeat (ncyc) @(negedge clock);
	endtask

	// Add with overflow, pair increment, then the pointer store modes
	task automatic test_alu;
		run_prog('{16'h770f, 16'h7011, 16'h0211, 16'hac10, 16'h0100,
			16'h7f8f, 16'h3001, 16'hac18, 16'h0101, 16'hac19, 16'h0102,
			16'h70a3, 16'h70b1, 16'ha911, 16'ha810, 16'haa18, 16'hab19,
			16'h0003}, 30);
		check_cnt("first store cycle", 5, first_we);
		check8("add flags", 8'h2c, we_flags);
		check8("add sum", 8'h80, mem.dram[12'h100]);
		check8("pair low", 8'h00, mem.dram[12'h101]);
		check8("pair high", 8'h01, mem.dram[12'h102]);
		check8("pre-dec store", 8'h00, mem.dram[12'h103]);
		check8("post-inc then ind", 8'h80, mem.dram[12'h104]);
		check8("disp store", 8'h01, mem.dram[12'h106]);
	endtask

	// All six multiply variants on operands that tell them apart
	task automatic test_mul;
		logic [15:0] prod [6];
		prod = '{16'h81fa, 16'h00fa, 16'hfefa, 16'h03f4, 16'h01f4, 16'hfdf4};
		for (int v = 0; v < 6; v++)
		begin
			run_prog('{16'h7f0e, 16'h7813,
				16'(16'h2001 | (v % 3) << 10 | (v / 3) << 8),
				16'hac00, 16'h0100, 16'hac01, 16'h0101}, 30);
			check_cnt("mul store cycle", 6, first_we);
			check16("product", prod[v],
				{mem.dram[12'h101], mem.dram[12'h100]});
		end
	endtask

	// Push, relative call, return, pop
	task automatic test_stack;
		run_prog('{16'h7a05, 16'hb010, 16'he006, 16'hac11, 16'h0100,
			16'hb812, 16'hac12, 16'h0101, 16'hdfff, 16'h731c, 16'hf400}, 40);
		check8("pushed byte", 8'ha5, mem.dram[12'hfff]);
		check8("return low", 8'h03, mem.dram[12'hffe]);
		check8("return high", 8'h00, mem.dram[12'hffd]);
		check8("call result", 8'h3c, mem.dram[12'h100]);
		check8("popped byte", 8'ha5, mem.dram[12'h101]);
		check16("stack after", 16'h0fff, stack_pointer);
		check_cnt("write count", 5, nwr);
	endtask

	// Stack moved before interrupts are enabled, then a held-off request
	task automatic test_irq;
		logic [15:0] p[$];
		p = '{16'h7f00, 16'hcfb0, 16'h96e0, 16'h7040, 16'h7041, 16'h7042};
		while (p.size() < 16)
			p.push_back(16'hdfff);
		p.push_back(16'h7050);
		p.push_back(16'hf500);
		irq_arm = 1'b1;
		run_prog(p, 40);
		irq_arm = 1'b0;
		check_cnt("hold-off", 5, ack_cyc - sp_cyc);
		check8("irq return low", 8'h06, mem.dram[12'hff0]);
		check8("irq return high", 8'h00, mem.dram[12'hfef]);
		check_cnt("irq writes", 2, nwr);
		check16("stack after exit", 16'h0ff0, stack_pointer);
	endtask

	// Main sequence
	initial
	begin
		reset = 1'b1;
		irq_arm = 1'b0;
		irq_vector = 16'h0010;
		num_errors = 0;
		compares = 0;
		tick = 0;
		cyc = 0;
		nwr = 0;
		first_we = -1;
		sp_cyc = -1;
		ack_cyc = -1;
		test_alu;
		test_mul;
		test_stack;
		test_irq;
		summarize;
	end
endmodule
